// ==== pmw_pkg.sv ====
// package: offsets, fields, reset values and timing for the wake event status block
package pmw_pkg;
  localparam logic [6:0] PMW_STATUS_OFFSET = 7'h00;
  localparam logic [6:0] PMW_ENABLE_OFFSET = 7'h02;
  localparam int PMW_BIT_WAKE = 15;
  localparam int PMW_BIT_OVERRIDE = 11;
  localparam int PMW_BIT_ALARM = 10;
  localparam int PMW_BIT_BUTTON = 8;
  localparam logic [15:0] PMW_STATUS_RESET = 16'h0000;
  localparam logic [15:0] PMW_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] PMW_STATUS_MASK = 16'h8d00;
  localparam logic [15:0] PMW_ENABLE_MASK = 16'h0500;
  localparam longint PMW_CLK_HZ = 20000000;
  localparam longint PMW_SLOW_HZ = 32768;
  localparam int PMW_SLOW_DIV = int'(PMW_CLK_HZ / PMW_SLOW_HZ);
  localparam int PMW_OVERRIDE_S = 4;
  localparam int PMW_OVERRIDE_TICKS = int'(PMW_OVERRIDE_S * PMW_SLOW_HZ);
  typedef enum logic [1:0] {PMW_WORKING, PMW_SLEEPING, PMW_SOFT_OFF} pmw_state_t;
endpackage : pmw_pkg

// ==== pmw_button_timer.sv ====
// power button hold timer on a slow tick
`timescale 1ns/100ps
`default_nettype none
module pmw_button_timer
  import pmw_pkg::*;
#(
  parameter int SLOW_DIV = PMW_SLOW_DIV,
  parameter int HOLD_TICKS = PMW_OVERRIDE_TICKS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic pressed,
  output logic expired
);
  logic [15:0] div_count;
  logic slow_tick;
  logic [31:0] hold_count;

  always_ff @(posedge clk) begin
    if (reset || div_count == 16'(SLOW_DIV - 1)) begin
      div_count <= 16'h0000;
    end else begin
      div_count <= div_count + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    slow_tick <= !reset && div_count == 16'(SLOW_DIV - 1);
  end

  // restart whenever released; one pulse when hold reached
  always_ff @(posedge clk) begin
    if (reset || !pressed) begin
      hold_count <= 32'h00000000; // [RQ19]
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (slow_tick && hold_count != 32'(HOLD_TICKS)) begin
        hold_count <= hold_count + 32'h00000001;
        expired <= hold_count == 32'(HOLD_TICKS - 1); // [RQ8]
      end
    end
  end
endmodule : pmw_button_timer
`default_nettype wire

// ==== pmw_wake_status.sv ====
// upper half of the first power management event status register
`timescale 1ns/100ps
`default_nettype none
// Contract
// [RQ1] enabled alarm or button status raises wake
// [RQ2] working state: SCI if routed, else SMI
// [RQ3] bits 5 and 0 never wake
// [RQ4] wake flag set only after sleep entry
// [RQ5] wake flag returns system to working
// [RQ6] wake flag write-one-clear, resume reset clears
// [RQ7] no wake flag after unplanned power loss
// [RQ8] override flag after four second hold
// [RQ9] override forces soft-off, sets power-loss flag
// [RQ10] override flag survives hard reset, power loss
// [RQ11] alarm interrupt sets alarm flag
// [RQ12] alarm flag write-one-clear, resume reset clears
// [RQ13] button low sets button flag always
// [RQ14] working: enabled button raises SCI or SMI
// [RQ15] sleeping: enabled button raises wake
// [RQ16] long hold clears button flag, soft-off
// [RQ17] software writes one to clear button
// [RQ18] reserved bits read zero, writes ignored
// [RQ19] hold timed by slow counter, restarts
module pmw_wake_status
  import pmw_pkg::*;
#(
  parameter int SLOW_DIV = PMW_SLOW_DIV,
  parameter int HOLD_TICKS = PMW_OVERRIDE_TICKS
) (
  // clock and resets
  input wire logic CLK,
  input wire logic RESET,
  input wire logic RESUME_WELL_RESET_N,
  input wire logic HARD_RESET,
  // register port
  input wire logic [6:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] WDATA,
  output logic [15:0] RDATA,
  // platform inputs
  input wire logic POWER_BUTTON_N,
  input wire logic ALARM_INTERRUPT_N,
  input wire logic SLEEP_ENTRY_ENABLE,
  input wire logic ACPI_INTERRUPT_ROUTE_SELECT,
  input wire logic POWER_LOSS,
  // outputs
  output logic SCI,
  output logic SYSTEM_MANAGEMENT_INTERRUPT,
  output logic WAKE_EVENT,
  output logic SOFT_OFF,
  output logic SLEEPING,
  output logic AFTER_POWER_LOSS_FLAG
);
  logic wake_status_flag;
  logic button_override_flag;
  logic alarm_status_flag;
  logic button_status_flag;
  logic alarm_event_enable;
  logic button_event_enable;
  logic entered_by_sleep;
  logic alarm_prev;
  logic button_prev;
  logic override_event;
  logic wr_status;
  logic wr_enable;
  logic wake_cond;
  logic pm_event;
  logic resume_reset;
  pmw_state_t state;
  pmw_state_t next_state;

  function automatic logic clear_hit(input logic [15:0] data, input int pos);
    return data[pos];
  endfunction : clear_hit

  assign resume_reset = RESET || !RESUME_WELL_RESET_N;
  assign wr_status = WR && ADDR == PMW_STATUS_OFFSET;
  assign wr_enable = WR && ADDR == PMW_ENABLE_OFFSET;
  // only alarm and button reach wake; bits 5 and 0 not wired
  assign wake_cond = (alarm_status_flag && alarm_event_enable) ||
                     (button_status_flag && button_event_enable); // [RQ1] [RQ3] [RQ15]
  assign pm_event = wake_cond;

  pmw_button_timer #(
    .SLOW_DIV(SLOW_DIV),
    .HOLD_TICKS(HOLD_TICKS)
  ) u_timer (
    .clk(CLK),
    .reset(resume_reset),
    .pressed(!POWER_BUTTON_N),
    .expired(override_event)
  );

  always_ff @(posedge CLK) begin
    if (resume_reset) begin
      alarm_prev <= 1'b0;
      button_prev <= 1'b0;
    end else begin
      alarm_prev <= !ALARM_INTERRUPT_N;
      button_prev <= !POWER_BUTTON_N;
    end
  end

  // enables; override leaves only the button as wake source
  always_ff @(posedge CLK) begin
    if (resume_reset) begin
      alarm_event_enable <= PMW_ENABLE_RESET[PMW_BIT_ALARM];
      button_event_enable <= PMW_ENABLE_RESET[PMW_BIT_BUTTON];
    end else if (override_event) begin
      alarm_event_enable <= 1'b0; // [RQ16]
      button_event_enable <= 1'b1; // [RQ16]
    end else if (wr_enable) begin
      alarm_event_enable <= WDATA[PMW_BIT_ALARM];
      button_event_enable <= WDATA[PMW_BIT_BUTTON];
    end
  end

  // hard reset is deliberately not a term of any status flag
  always_ff @(posedge CLK) begin
    if (resume_reset) begin
      alarm_status_flag <= PMW_STATUS_RESET[PMW_BIT_ALARM]; // [RQ12]
    end else if (!ALARM_INTERRUPT_N && !alarm_prev) begin
      alarm_status_flag <= 1'b1; // [RQ11]
    end else if (wr_status && clear_hit(WDATA, PMW_BIT_ALARM)) begin
      alarm_status_flag <= 1'b0; // [RQ12]
    end
  end

  always_ff @(posedge CLK) begin
    if (resume_reset) begin
      button_status_flag <= PMW_STATUS_RESET[PMW_BIT_BUTTON];
    end else if (override_event) begin
      button_status_flag <= 1'b0; // [RQ16]
    end else if (!POWER_BUTTON_N && !button_prev) begin
      // press edge only: a button still held after override must not wake again
      button_status_flag <= 1'b1; // [RQ13]
    end else if (wr_status && clear_hit(WDATA, PMW_BIT_BUTTON)) begin
      button_status_flag <= 1'b0; // [RQ17]
    end
  end

  // always-powered well: only RESET clears, plus a write of one to the override bit for the override flag; not resume reset or power loss
  always_ff @(posedge CLK) begin
    if (RESET) begin
      button_override_flag <= PMW_STATUS_RESET[PMW_BIT_OVERRIDE];
      AFTER_POWER_LOSS_FLAG <= 1'b0;
    end else if (override_event) begin
      button_override_flag <= 1'b1; // [RQ8] [RQ10]
      AFTER_POWER_LOSS_FLAG <= 1'b1; // [RQ9]
    end else if (wr_status && clear_hit(WDATA, PMW_BIT_OVERRIDE)) begin
      button_override_flag <= 1'b0; // [RQ10]
    end
  end

  // remembers that sleep was entered through the sleep enable
  always_ff @(posedge CLK) begin
    if (resume_reset || POWER_LOSS) begin
      entered_by_sleep <= 1'b0; // [RQ7]
    end else if (state == PMW_WORKING && SLEEP_ENTRY_ENABLE) begin
      entered_by_sleep <= 1'b1;
    end else if (state == PMW_WORKING) begin
      entered_by_sleep <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (resume_reset) begin
      wake_status_flag <= PMW_STATUS_RESET[PMW_BIT_WAKE]; // [RQ6]
    end else if (state != PMW_WORKING && entered_by_sleep && wake_cond) begin
      wake_status_flag <= 1'b1; // [RQ4]
    end else if (wr_status && clear_hit(WDATA, PMW_BIT_WAKE)) begin
      wake_status_flag <= 1'b0; // [RQ6]
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      PMW_WORKING: begin
        if (SLEEP_ENTRY_ENABLE) begin
          next_state = PMW_SLEEPING;
        end
      end
      PMW_SLEEPING, PMW_SOFT_OFF: begin
        if (wake_status_flag || (wake_cond && !entered_by_sleep)) begin
          next_state = PMW_WORKING; // [RQ5]
        end
      end
      default: begin
        next_state = PMW_WORKING;
      end
    endcase
    if (override_event) begin
      next_state = PMW_SOFT_OFF; // [RQ9] [RQ16]
    end
    // resets folded in so the state outputs follow them too
    if (HARD_RESET) begin
      next_state = PMW_WORKING;
    end
    if (POWER_LOSS) begin
      next_state = PMW_SOFT_OFF;
    end
  end

  always_ff @(posedge CLK) begin
    if (resume_reset) begin
      state <= PMW_SOFT_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK) begin
    if (resume_reset) begin
      SCI <= 1'b0;
      SYSTEM_MANAGEMENT_INTERRUPT <= 1'b0;
      WAKE_EVENT <= 1'b0;
      SOFT_OFF <= 1'b1;
      SLEEPING <= 1'b0;
    end else begin
      SCI <= state == PMW_WORKING && pm_event && ACPI_INTERRUPT_ROUTE_SELECT; // [RQ2] [RQ14]
      SYSTEM_MANAGEMENT_INTERRUPT <= state == PMW_WORKING && pm_event &&
                                     !ACPI_INTERRUPT_ROUTE_SELECT; // [RQ2] [RQ14]
      WAKE_EVENT <= state != PMW_WORKING && wake_cond; // [RQ1] [RQ15]
      SOFT_OFF <= next_state == PMW_SOFT_OFF;
      SLEEPING <= next_state == PMW_SLEEPING;
    end
  end

  // read data; reserved bits zero
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RDATA <= 16'h0000;
    end else if (RD && ADDR == PMW_STATUS_OFFSET) begin
      RDATA <= {wake_status_flag, 3'h0, button_override_flag, alarm_status_flag, 1'b0,
                button_status_flag, 8'h00} & PMW_STATUS_MASK; // [RQ18]
    end else if (RD && ADDR == PMW_ENABLE_OFFSET) begin
      RDATA <= {5'h00, alarm_event_enable, 1'b0, button_event_enable, 8'h00} & PMW_ENABLE_MASK;
    end else begin
      RDATA <= 16'h0000;
    end
  end
endmodule : pmw_wake_status
`default_nettype wire

// ==== pmw_wake_status_chk.sv ====
// assertion checker for the wake event status block
`timescale 1ns/100ps
`default_nettype none
module pmw_chk
  import pmw_pkg::*;
#(
  parameter int SLOW_DIV = 4,
  parameter int HOLD_TICKS = 8
) (
  // clock, resets, register port
  input wire logic CLK,
  input wire logic RESET,
  input wire logic RESUME_WELL_RESET_N,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  // routing and outputs
  input wire logic ACPI_INTERRUPT_ROUTE_SELECT,
  input wire logic SCI,
  input wire logic SYSTEM_MANAGEMENT_INTERRUPT,
  input wire logic WAKE_EVENT,
  input wire logic SLEEPING,
  input wire logic SOFT_OFF,
  input wire logic AFTER_POWER_LOSS_FLAG
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RESET || !RESUME_WELL_RESET_N);
  chk_rd_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data not idle");
  chk_rsvd_zero: assert property ($past(RD) |-> (RDATA & ~PMW_STATUS_MASK) == 16'h0000)
    else $error("reserved bit read");
  chk_sci_route: assert property (SCI |-> $past(ACPI_INTERRUPT_ROUTE_SELECT))
    else $error("sci not routed");
  chk_smi_route: assert property (SYSTEM_MANAGEMENT_INTERRUPT |-> !$past(ACPI_INTERRUPT_ROUTE_SELECT))
    else $error("smi not routed");
  chk_irq_working: assert property (SCI || SYSTEM_MANAGEMENT_INTERRUPT |-> !$past(SLEEPING))
    else $error("interrupt in sleep");
  chk_wake_asleep: assert property (WAKE_EVENT |-> $past(SLEEPING || SOFT_OFF))
    else $error("wake while working");
  chk_wake_return: assert property (WAKE_EVENT && SLEEPING |-> ##[1:4] !SLEEPING)
    else $error("no return to working");
  chk_apl_sticky: assert property ($past(AFTER_POWER_LOSS_FLAG) |-> AFTER_POWER_LOSS_FLAG)
    else $error("power loss flag dropped");
  cov_sci: cover property (SCI);
  cov_smi: cover property (SYSTEM_MANAGEMENT_INTERRUPT);
  cov_wake: cover property (WAKE_EVENT && SLEEPING);
endmodule : pmw_chk
bind pmw_wake_status pmw_chk #(.SLOW_DIV(SLOW_DIV), .HOLD_TICKS(HOLD_TICKS)) chk_u (.CLK, .RESET,
  .RESUME_WELL_RESET_N, .RD, .RDATA, .ACPI_INTERRUPT_ROUTE_SELECT, .SCI, .SYSTEM_MANAGEMENT_INTERRUPT,
  .WAKE_EVENT, .SLEEPING, .SOFT_OFF, .AFTER_POWER_LOSS_FLAG);
`default_nettype wire

// ==== pmw_platform_model.sv ====
// platform side: power button and alarm source
`timescale 1ns/100ps
`default_nettype none
module pmw_platform_model (
  // commands
  input wire logic clk,
  input wire logic press,
  input wire logic alarm,
  // pins
  output var logic button_n = 1'b1,
  output var logic alarm_n = 1'b1
);
  always @(posedge clk) begin
    button_n <= !press;
    alarm_n <= !alarm;
  end
endmodule : pmw_platform_model
`default_nettype wire

// ==== pmw_wake_status_tb.sv ====
// self-checking bench for the wake event status block
`timescale 1ns/100ps
`default_nettype none
module pmw_wake_status_tb import pmw_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, rsm_n = 1'b1, wr = 1'b0, rd = 1'b0, route = 1'b1;
  logic press = 1'b0, alarm = 1'b0, slp = 1'b0, hrst = 1'b0, pwr = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [15:0] wdata = 16'h0000, v;
  wire logic [15:0] rdata;
  wire logic btn_n, alm_n, sci, smi, wake, soff, slping, apl;
  int fails = 0, cmp_count = 0;
  always #25 clk = !clk;
  pmw_platform_model pm_u (.clk, .press, .alarm, .button_n(btn_n), .alarm_n(alm_n));
  pmw_wake_status #(.SLOW_DIV(4), .HOLD_TICKS(8)) dut_u (.CLK(clk), .RESET(rst), .RESUME_WELL_RESET_N(rsm_n),
    .HARD_RESET(hrst), .ADDR(addr), .WR(wr), .RD(rd), .WDATA(wdata), .RDATA(rdata), .POWER_BUTTON_N(btn_n),
    .ALARM_INTERRUPT_N(alm_n), .SLEEP_ENTRY_ENABLE(slp), .ACPI_INTERRUPT_ROUTE_SELECT(route), .POWER_LOSS(pwr),
    .SCI(sci), .SYSTEM_MANAGEMENT_INTERRUPT(smi), .WAKE_EVENT(wake), .SOFT_OFF(soff), .SLEEPING(slping),
    .AFTER_POWER_LOSS_FLAG(apl));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic bus(input logic w, input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    {wr, rd, addr, wdata} <= {w, !w, a, d};
    @(posedge clk);
    {wr, rd} <= 2'b00;
    #1 v = rdata;
  endtask : bus
  task automatic rdc(input string nm, input logic [6:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(nm, v, e);
  endtask : rdc
  // 0 hard reset, 1 sleep entry, 2 alarm, 3 button, 4 power loss
  task automatic kick(input int s, input int n);
    @(posedge clk);
    {pwr, press, alarm, slp, hrst} <= 5'h01 << s;
    repeat (n) @(posedge clk);
    {pwr, press, alarm, slp, hrst} <= 5'h00;
    repeat (3) @(posedge clk);
  endtask : kick
  // 0 sci, 1 smi, 2 wake, 3 soft off, 4 sleeping, 5 working
  task automatic wait_hi(input int k);
    logic [5:0] o;
    for (int i = 0; i < 200 && o[k] !== 1'b1; i++) begin
      @(posedge clk);
      #1 o = {!slping && !soff, slping, soff, wake, smi, sci};
    end
    chk("output level", {15'h0000, o[k]}, 16'h0001);
    if (o[k] !== 1'b1)
      conclude();
  endtask : wait_hi
  task automatic t_regs();
    rdc("status reset", PMW_STATUS_OFFSET, PMW_STATUS_RESET);
    bus(1'b1, PMW_STATUS_OFFSET, 16'hffff);
    rdc("status ones", PMW_STATUS_OFFSET, 16'h0000);
    bus(1'b1, PMW_ENABLE_OFFSET, 16'hffff);
    rdc("enable", PMW_ENABLE_OFFSET, PMW_ENABLE_MASK);
    rdc("unmapped", 7'h04, 16'h0000);
    kick(0, 1);
    wait_hi(5);
  endtask : t_regs
  task automatic t_button();
    kick(3, 3);
    wait_hi(0);
    rdc("button", PMW_STATUS_OFFSET, 16'h0100);
    @(posedge clk);
    route <= 1'b0;
    wait_hi(1);
    bus(1'b1, PMW_STATUS_OFFSET, 16'h0000);
    rdc("write zero", PMW_STATUS_OFFSET, 16'h0100);
    bus(1'b1, PMW_STATUS_OFFSET, 16'h0100);
    rdc("write one", PMW_STATUS_OFFSET, 16'h0000);
  endtask : t_button
  task automatic t_alarm();
    kick(2, 1);
    rdc("alarm awake", PMW_STATUS_OFFSET, 16'h0400);
    bus(1'b1, PMW_STATUS_OFFSET, 16'h0400);
    kick(1, 1);
    wait_hi(4);
    @(posedge clk);
    alarm <= 1'b1;
    @(posedge clk);
    alarm <= 1'b0;
    wait_hi(2);
    wait_hi(5);
    rdc("wake", PMW_STATUS_OFFSET, 16'h8400);
    kick(0, 1);
    rdc("hard reset", PMW_STATUS_OFFSET, 16'h8400);
    bus(1'b1, PMW_STATUS_OFFSET, 16'h8400);
    rdc("flags clear", PMW_STATUS_OFFSET, 16'h0000);
  endtask : t_alarm
  task automatic t_override();
    kick(3, 60);
    wait_hi(3);
    chk("power loss", {15'h0000, apl}, 16'h0001);
    bus(1'b0, PMW_STATUS_OFFSET, 16'h0000);
    chk("override", v & 16'h0800, 16'h0800);
    rdc("enables", PMW_ENABLE_OFFSET, 16'h0100);
    kick(0, 1);
    rsm_n <= 1'b0;
    @(posedge clk);
    rsm_n <= 1'b1;
    rdc("resume", PMW_STATUS_OFFSET, 16'h0800);
  endtask : t_override
  task automatic t_power_loss();
    bus(1'b1, PMW_ENABLE_OFFSET, 16'h0400);
    kick(0, 1);
    kick(1, 1);
    wait_hi(4);
    kick(4, 1);
    wait_hi(3);
    kick(2, 1);
    wait_hi(5);
    rdc("power restored", PMW_STATUS_OFFSET, 16'h0c00);
  endtask : t_power_loss
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_button();
    t_alarm();
    t_override();
    t_power_loss();
    conclude();
  end
endmodule : pmw_wake_status_tb
`default_nettype wire
